// ---- hw/irqcfg_params.svh ----
// offsets, field positions, reset values and timing counts of the irq block
`ifndef IRQCFG_PARAMS_SVH
`define IRQCFG_PARAMS_SVH

// register byte offsets
`define IRQCFG_CFG_OFS       12'h054
`define IRQCFG_EVT_STS_OFS   12'h100
`define IRQCFG_EVT_EN_OFS    12'h104
`define IRQCFG_EVT_CLR_OFS   12'h108

// interrupt_pin_config field positions
`define IRQCFG_INTERVAL_HI   31
`define IRQCFG_INTERVAL_LO   24
`define IRQCFG_CLR_BIT       14
`define IRQCFG_ACTIVE_BIT    13
`define IRQCFG_MASTER_BIT    12
`define IRQCFG_OUT_EN_BIT    8
`define IRQCFG_POL_BIT       4
`define IRQCFG_CLKSEL_BIT    1
`define IRQCFG_TYPE_BIT      0

// event status / enable / clear layout
`define IRQCFG_EVT_START_BIT 0
`define IRQCFG_EVT_END_BIT   1
`define IRQCFG_EVT_W         2

// reset values
`define IRQCFG_CFG_RESET     32'h0000_0000
`define IRQCFG_RD_ZERO       32'h0000_0000

// timing: clock period and interval step, both in ns
`define IRQCFG_CLK_PERIOD_NS 100
`define IRQCFG_STEP_TIME_NS  10000
// least time, so round up to whole cycles
`define IRQCFG_STEP_CYCLES \
    ((`IRQCFG_STEP_TIME_NS + `IRQCFG_CLK_PERIOD_NS - 1) / `IRQCFG_CLK_PERIOD_NS)
`define IRQCFG_PRE_W         7

`endif

// ---- hw/irqcfg_pkg.sv ----
// types shared by the irq output configuration block
`default_nettype none

package irqcfg_pkg;

    // interval state, binary codes written out
    typedef enum logic [0:0] {
        IRQCFG_IDLE = 1'b0,   // pin follows the interrupt line
        IRQCFG_HOLD = 1'b1    // de-assertion interval running
    } irqcfg_hold_t;

    // all state of the main block
    typedef struct packed {
        logic [7:0]   interval;   // de-assertion interval in 10 us steps
        logic         out_en;     // pin output enable
        logic         pol;        // push-pull asserted level
        logic         pin_type;   // 0 open-drain, 1 push-pull
        logic         clk_sel;    // crystal clock onto the pin
        irqcfg_hold_t state;      // interval state
        logic [7:0]   count;      // steps left in the interval
        logic         pin_act;    // functional pin request, registered
        logic         pin_out;    // pin output value
        logic         pin_oe;     // pin output enable
        logic         xtal_meta;  // crystal sync, first stage
        logic         xtal_sync;  // crystal sync, second stage
        logic [1:0]   evt_sts;    // sticky event status
        logic [1:0]   evt_en;     // event interrupt enables
        logic [31:0]  rd_data;    // read data register
    } irqcfg_state_t;

    // state of the step prescaler
    typedef struct packed {
        logic [6:0] count;        // cycles into the current step
    } irqcfg_pre_t;

endpackage : irqcfg_pkg

`default_nettype wire

// ---- hw/irqcfg_tick.sv ----
// prescaler that makes the 10 us step pulse from the system clock
`timescale 1ns/1ns
`default_nettype none
`include "irqcfg_params.svh"

module irqcfg_tick
    import irqcfg_pkg::*;
(
    input  wire logic clk_sys,   // system clock
    input  wire logic reset_n,   // asynchronous reset, active low
    input  wire logic restart,   // start a fresh step from zero
    output logic      tick       // one-cycle pulse at the end of a step
);

    localparam logic [`IRQCFG_PRE_W-1:0] LAST =
        `IRQCFG_PRE_W'(`IRQCFG_STEP_CYCLES - 1);

    irqcfg_pre_t q;       // registered state
    irqcfg_pre_t next_q;  // next state

    // restart wins over the pulse so a fresh interval gets a full step
    assign tick = (q.count == LAST) && !restart;

    // next count: wrap at the last cycle of a step
    always_comb begin
        next_q = q;
        if (restart || q.count == LAST) begin
            next_q.count = '0;
        end else begin
            next_q.count = q.count + `IRQCFG_PRE_W'(1);
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

endmodule : irqcfg_tick
`default_nettype wire

// ---- hw/irqcfg_top.sv ----
// interrupt pin configuration, de-assertion interval and pin driver
`timescale 1ns/1ns
`default_nettype none
`include "irqcfg_params.svh"

module irqcfg_top
    import irqcfg_pkg::*;
(
    input  wire logic        clk_sys,               // 10 MHz system clock
    input  wire logic        reset_n,               // async reset, active low
    input  wire logic        soft_reset,            // digital soft reset pulse
    input  wire logic [11:0] addr,                  // register byte address
    input  wire logic [31:0] wr_data,               // write data
    input  wire logic        wr_en,                 // write strobe
    input  wire logic        rd_en,                 // read strobe
    output logic      [31:0] rd_data,               // read data, next cycle
    input  wire logic        irq_line,              // enabled sources, ored
    input  wire logic        power_event_interrupt, // enabled power event
    input  wire logic        xtal_clk,              // crystal clock level
    output logic             irq_pin_out,           // pin output value
    output logic             irq_pin_oe,            // pin driven when high
    output logic             irq_event              // block event interrupt
);

    irqcfg_state_t q;            // registered state
    irqcfg_state_t next_q;       // next state
    logic          step_tick;    // one-cycle 10 us step pulse
    logic          wr_cfg;       // write to the configuration register
    logic [7:0]    new_interval; // interval field of the write data
    logic          master;       // internal interrupt line
    logic          req;          // functional pin request this cycle
    logic          start;        // pin request dropping, interval to begin
    logic          clr_start;    // clear bit restarting the interval
    logic          restart;      // prescaler restart

    // decode and combinational terms shared by the prescaler and the fsm
    assign wr_cfg       = wr_en && (addr == `IRQCFG_CFG_OFS);
    assign new_interval = wr_data[`IRQCFG_INTERVAL_HI:`IRQCFG_INTERVAL_LO];
    assign master       = irq_line || power_event_interrupt;
    // held interrupts stay off the pin, power event never waits
    assign req = q.out_en && ((irq_line && q.state == IRQCFG_IDLE)
                 || power_event_interrupt);
    // any drop of the pin request opens an interval, unless the interval field is zero
    assign start = q.pin_act && !req && (q.interval != 8'h00);
    // a clear with a zero interval has nothing to restart
    assign clr_start = wr_cfg && wr_data[`IRQCFG_CLR_BIT]
                       && (new_interval != 8'h00);
    assign restart = start || clr_start;

    // 10 us step pulses, realigned at each fresh interval
    irqcfg_tick u_tick (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .restart (restart),
        .tick    (step_tick)
    );

    // next state of the whole block
    always_comb begin
        logic act_level;  // asserted level of the pin
        logic level;      // level the pin should show
        logic [1:0] set;  // event bits raised this cycle
        act_level = 1'b0;
        level     = 1'b1;
        set       = 2'b00;
        next_q    = q;

        // crystal clock crosses in through two flops
        next_q.xtal_meta = xtal_clk;
        next_q.xtal_sync = q.xtal_meta;

        // interval fsm
        next_q.pin_act = req;
        if (start) begin
            // interval length taken from the field at this moment
            next_q.state = IRQCFG_HOLD;
            next_q.count = q.interval;
        end else begin
            case (q.state)
                IRQCFG_IDLE: begin
                    next_q.count = 8'h00;
                end
                IRQCFG_HOLD: begin
                    if (step_tick) begin
                        if (q.count <= 8'h01) begin
                            // last step done, release to the pin
                            next_q.state = IRQCFG_IDLE;
                            next_q.count = 8'h00;
                        end else begin
                            next_q.count = q.count - 8'h01;
                        end
                    end
                end
                default: begin
                    next_q.state = IRQCFG_IDLE;
                    next_q.count = 8'h00;
                end
            endcase
        end

        // configuration write; clear bit is not stored
        if (wr_cfg) begin
            next_q.interval = new_interval;
            next_q.out_en   = wr_data[`IRQCFG_OUT_EN_BIT];
            next_q.pol      = wr_data[`IRQCFG_POL_BIT];
            next_q.clk_sel  = wr_data[`IRQCFG_CLKSEL_BIT];
            next_q.pin_type = wr_data[`IRQCFG_TYPE_BIT];
            if (new_interval == 8'h00) begin
                // disable: pending interrupts go out next cycle
                next_q.state = IRQCFG_IDLE;
                next_q.count = 8'h00;
            end else if (clr_start) begin
                next_q.state = IRQCFG_HOLD;
                next_q.count = new_interval;
            end
        end

        // events: entering an interval and ending one
        set[`IRQCFG_EVT_START_BIT] = restart;
        set[`IRQCFG_EVT_END_BIT]   = q.state == IRQCFG_HOLD && step_tick
                                     && q.count <= 8'h01 && !restart;
        // a set in the same cycle as its clear is kept
        if (wr_en && addr == `IRQCFG_EVT_CLR_OFS) begin
            next_q.evt_sts = q.evt_sts & ~wr_data[1:0];
        end
        next_q.evt_sts = next_q.evt_sts | set;
        if (wr_en && addr == `IRQCFG_EVT_EN_OFS) begin
            next_q.evt_en = wr_data[1:0];
        end

        // pin driver: open-drain is always active low
        act_level = q.pin_type ? q.pol : 1'b0;
        if (q.clk_sel) begin
            level = q.xtal_sync;
        end else begin
            level = req ? act_level : ~act_level;
        end
        if (q.pin_type) begin
            next_q.pin_out = level;
            next_q.pin_oe  = 1'b1;
        end else begin
            // open-drain pulls low only, released otherwise
            next_q.pin_out = 1'b0;
            next_q.pin_oe  = ~level;
        end

        // register reads, unmapped addresses read zero
        if (rd_en) begin
            next_q.rd_data = `IRQCFG_RD_ZERO;
            case (addr)
                `IRQCFG_CFG_OFS: begin
                    next_q.rd_data[`IRQCFG_INTERVAL_HI:`IRQCFG_INTERVAL_LO]
                        = q.interval;
                    next_q.rd_data[`IRQCFG_ACTIVE_BIT] =
                        (q.state == IRQCFG_HOLD);
                    next_q.rd_data[`IRQCFG_MASTER_BIT] = master;
                    next_q.rd_data[`IRQCFG_OUT_EN_BIT] = q.out_en;
                    next_q.rd_data[`IRQCFG_POL_BIT]    = q.pol;
                    next_q.rd_data[`IRQCFG_CLKSEL_BIT] = q.clk_sel;
                    next_q.rd_data[`IRQCFG_TYPE_BIT]   = q.pin_type;
                end
                `IRQCFG_EVT_STS_OFS: begin
                    next_q.rd_data[1:0] = q.evt_sts;
                end
                `IRQCFG_EVT_EN_OFS: begin
                    next_q.rd_data[1:0] = q.evt_en;
                end
                default: begin
                    next_q.rd_data = `IRQCFG_RD_ZERO;
                end
            endcase
        end else begin
            // read data stand for one cycle only
            next_q.rd_data = `IRQCFG_RD_ZERO;
        end

        // soft reset keeps polarity and buffer type
        if (soft_reset) begin
            next_q.interval = 8'h00;
            // a write in the same cycle loses, retained bits stay put
            next_q.pol      = q.pol;
            next_q.pin_type = q.pin_type;
            next_q.out_en   = 1'b0;
            next_q.clk_sel  = 1'b0;
            next_q.state    = IRQCFG_IDLE;
            next_q.count    = 8'h00;
            next_q.evt_sts  = 2'b00;
            next_q.evt_en   = 2'b00;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    // outputs
    assign rd_data     = q.rd_data;
    assign irq_pin_out = q.pin_out;
    assign irq_pin_oe  = q.pin_oe;
    assign irq_event   = |(q.evt_sts & q.evt_en);

    // checks on the block's own behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_zero_disables: assert property (
        wr_cfg && new_interval == 8'h00 && !soft_reset
        |=> q.state == IRQCFG_IDLE && q.count == 8'h00)
        else $error("zero interval did not end the interval");

    a_clear_restarts: assert property (
        clr_start && !soft_reset
        |=> q.state == IRQCFG_HOLD && q.count == $past(new_interval))
        else $error("clear bit did not restart the interval");

    a_status_bit: assert property (
        rd_en && addr == `IRQCFG_CFG_OFS
        |=> rd_data[`IRQCFG_ACTIVE_BIT] == ($past(q.state) == IRQCFG_HOLD))
        else $error("interval status bit wrong");

    a_master_bit: assert property (
        rd_en && addr == `IRQCFG_CFG_OFS
        |=> rd_data[`IRQCFG_MASTER_BIT] == $past(master))
        else $error("master bit does not follow the line");

    a_pin_off: assert property (
        !q.out_en && !q.clk_sel && !q.pin_type |=> !irq_pin_oe)
        else $error("pin driven while output disabled");

    a_push_pull: assert property (
        q.pin_type && !q.clk_sel && q.out_en && power_event_interrupt
        |=> irq_pin_oe && irq_pin_out == $past(q.pol))
        else $error("push-pull level does not follow polarity");

    a_open_drain: assert property (
        !q.pin_type |=> !irq_pin_out)
        else $error("open-drain pin driven high");

    a_hold_blocks: assert property (
        q.state == IRQCFG_HOLD && !power_event_interrupt |=> !q.pin_act)
        else $error("interrupt reached pin during interval");

    a_start_drop: assert property (
        start && !wr_cfg && !soft_reset
        |=> q.state == IRQCFG_HOLD && q.count == $past(q.interval))
        else $error("pin drop did not start the interval");

    a_step_end: assert property (
        q.state == IRQCFG_HOLD && q.count == 8'h01 && step_tick
        && !start && !wr_cfg |=> q.state == IRQCFG_IDLE)
        else $error("interval did not end on its last step");

    a_retained: assert property (
        soft_reset |=> q.pol == $past(q.pol)
        && q.pin_type == $past(q.pin_type) && !q.out_en)
        else $error("soft reset disturbed retained bits");

endmodule : irqcfg_top
`default_nettype wire

// ---- dv/irqcfg_host.sv ----
// host side of the interrupt pin: a shared wire with a pull-up
`timescale 1ns/1ns
`default_nettype none

module irqcfg_host (
    input  wire logic pin_out,  // device pin value
    input  wire logic pin_oe,   // device drives the pin
    output logic      pin_level // level at the host input
);
    // a released wire floats up, so wired-or sharing stays safe
    assign pin_level = pin_oe ? pin_out : 1'b1;
endmodule : irqcfg_host

`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the irq pin configuration block
`timescale 1ns/1ns
`default_nettype none
`include "irqcfg_params.svh"

module tb;
    localparam logic [11:0] A_CFG = `IRQCFG_CFG_OFS;     // config register
    localparam logic [11:0] A_STS = `IRQCFG_EVT_STS_OFS; // event status
    localparam logic [11:0] A_EN  = `IRQCFG_EVT_EN_OFS;  // event enable
    localparam logic [11:0] A_CLR = `IRQCFG_EVT_CLR_OFS; // event clear
    logic        clk_sys;     // 10 MHz clock
    logic        reset_n;     // async reset, active low
    logic        soft_reset;  // digital soft reset
    logic [11:0] addr;        // register address
    logic [31:0] wr_data;     // write data
    logic        wr_en;       // write strobe
    logic        rd_en;       // read strobe
    logic [31:0] rd_data;     // read data
    logic        irq_line;    // internal interrupt line
    logic        pwr_evt;     // power event request
    logic        xtal_clk;    // crystal clock level
    logic        pin_out;     // pin value
    logic        pin_oe;      // pin drive enable
    logic        irq_event;   // block event interrupt
    logic        pin_level;   // wire level at the host
    logic [31:0] seed;        // xorshift state
    logic [31:0] cfg;         // config value under test
    logic        line;        // random line level
    logic        pwr;         // random power event level
    logic        act;         // expected pin request
    int          n_fail;      // mismatches
    int          check_count; // comparisons

    irqcfg_top DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .soft_reset(soft_reset), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .irq_line(irq_line), .power_event_interrupt(pwr_evt),
        .xtal_clk(xtal_clk), .irq_pin_out(pin_out),
        .irq_pin_oe(pin_oe), .irq_event(irq_event));
    irqcfg_host HOST (.pin_out(pin_out), .pin_oe(pin_oe),
        .pin_level(pin_level));

    // free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // expected wire level; a released open-drain reads the pull-up
    function automatic logic pin_exp(input logic typ, pol, act);
        return typ ? (act ? pol : ~pol) : ~act;
    endfunction : pin_exp

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic exp);
        chk_reg({31'h0, pin_level}, {31'h0, exp});
    endtask : chk_pin

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        chk_reg(rd_data, exp);
    endtask : rd_chk

    // bounded wait for a pin level; running out ends the run
    task automatic wait_pin(input logic exp, input int lim);
        int k;
        k = 0;
        while (pin_level !== exp && k < lim) begin
            cyc(1);
            k++;
        end
        chk_pin(exp);
        if (pin_level !== exp) begin
            end_sim();
        end
    endtask : wait_pin

    task automatic drive(input logic ln, input logic pe);
        @(posedge clk_sys);
        irq_line <= ln;
        pwr_evt <= pe;
    endtask : drive

    initial begin
        seed = 32'hd0dc_f5a5;
        n_fail = 0;
        check_count = 0;
        reset_n = 1'b0;
        soft_reset = 1'b0;
        addr = 12'h000;
        wr_data = 32'h0000_0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        irq_line = 1'b0;
        pwr_evt = 1'b0;
        xtal_clk = 1'b0;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        cyc(2);
        chk_pin(1'b1);
        rd_chk(A_CFG, 32'h0000_0000);
        wr(12'h0f0, 32'hffff_ffff);
        rd_chk(12'h0f0, 32'h0000_0000);
        rd_chk(A_CFG, 32'h0000_0000);
        $display("test reset done");
        // every enable, polarity and type with random line levels
        for (int i = 0; i < 8; i++) begin
            cfg = {23'h0, i[2], 3'h0, i[1], 3'h0, i[0]};
            wr(A_CFG, cfg);
            for (int j = 0; j < 3; j++) begin
                seed = xs(seed);
                line = seed[0];
                pwr = seed[1];
                drive(line, pwr);
                cyc(3);
                act = i[2] & (line | pwr);
                chk_pin(pin_exp(i[0], i[1], act));
                rd_chk(A_CFG, cfg | {19'h0, line | pwr, 12'h0});
            end
        end
        $display("test levels done");
        // two-step interval, push-pull, active high
        wr(A_CFG, 32'h0200_0111);
        drive(1'b1, 1'b0);
        cyc(3);
        chk_pin(1'b1);
        drive(1'b0, 1'b0);
        cyc(2);
        drive(1'b1, 1'b0);
        rd_chk(A_CFG, 32'h0200_3111);
        cyc(140);
        chk_pin(1'b0);
        wait_pin(1'b1, 100);
        rd_chk(A_CFG, 32'h0200_1111);
        drive(1'b0, 1'b0);
        cyc(4);
        chk_pin(1'b0);
        drive(1'b0, 1'b1);
        cyc(2);
        chk_pin(1'b1);
        drive(1'b1, 1'b0);
        cyc(3);
        chk_pin(1'b0);
        wr(A_CFG, 32'h0000_0111);
        cyc(2);
        chk_pin(1'b1);
        $display("test interval done");
        // shorter interval, then a fresh start by the clear bit
        wr(A_EN, 32'h0000_0003);
        wr(A_CFG, 32'h0100_0111);
        drive(1'b0, 1'b0);
        cyc(2);
        drive(1'b1, 1'b0);
        cyc(60);
        wr(A_CFG, 32'h0100_4111);
        cyc(80);
        chk_pin(1'b0);
        wait_pin(1'b1, 60);
        rd_chk(A_CFG, 32'h0100_1111);
        rd_chk(A_STS, 32'h0000_0003);
        chk_reg({31'h0, irq_event}, 32'h1);
        wr(A_EN, 32'h0000_0000);
        cyc(2);
        chk_reg({31'h0, irq_event}, 32'h0);
        wr(A_EN, 32'h0000_0003);
        wr(A_CLR, 32'h0000_0003);
        cyc(2);
        chk_reg({31'h0, irq_event}, 32'h0);
        rd_chk(A_STS, 32'h0000_0000);
        $display("test clear done");
        // soft reset keeps only polarity and type
        drive(1'b0, 1'b0);
        wr(A_CFG, 32'h0500_0111);
        @(posedge clk_sys);
        soft_reset <= 1'b1;
        @(posedge clk_sys);
        soft_reset <= 1'b0;
        rd_chk(A_CFG, 32'h0000_0011);
        rd_chk(A_EN, 32'h0000_0000);
        $display("test soft reset done");
        // crystal clock onto the pin, push-pull written again with the select
        wr(A_CFG, 32'h0000_0013);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            xtal_clk <= ~xtal_clk;
            cyc(5);
            chk_pin(xtal_clk);
        end
        $display("test clock select done");
        // a hard reset in mid-run returns the retained bits to default
        @(posedge clk_sys);
        reset_n <= 1'b0;
        cyc(3);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        cyc(2);
        chk_pin(1'b1);
        rd_chk(A_CFG, 32'h0000_0000);
        $display("test hard reset done");
        end_sim();
    end
endmodule : tb

`default_nettype wire
